// ==== pkg/sjd_pkg.sv ====
// Shared constants of the split/join compression datapath.
// Assumes a 32-bit AXI4-Lite register port and one display core clock.
package sjd_pkg;
  // Register map, byte addresses
  localparam int SJD_ADDR_W = 8;
  localparam logic [7:0] SJD_OFF_CTRL = 8'h00;
  localparam logic [7:0] SJD_OFF_HACT = 8'h04;
  localparam logic [7:0] SJD_OFF_PPS_E0 = 8'h08;
  localparam logic [7:0] SJD_OFF_PPS_E1 = 8'h0C;
  localparam logic [7:0] SJD_OFF_CRC_E0 = 8'h10;
  localparam logic [7:0] SJD_OFF_CRC_E1 = 8'h14;
  localparam logic [7:0] SJD_OFF_STAT = 8'h18;
  // Control fields
  localparam int SJD_CTRL_SPLIT = 0;
  localparam int SJD_CTRL_COMP = 1;
  localparam int SJD_CTRL_JOIN = 2;
  localparam int SJD_CTRL_BIGJ = 3;
  localparam int SJD_CTRL_HFLIP = 4;
  localparam int SJD_CTRL_ROT = 5;
  localparam int SJD_CTRL_SEL_LSB = 8;
  localparam logic [31:0] SJD_CTRL_MASK = 32'h0000033F;
  localparam logic [31:0] SJD_CTRL_RST = 32'h00000000;
  // Active width field
  localparam logic [31:0] SJD_HACT_MASK = 32'h0000FFFF;
  localparam logic [31:0] SJD_HACT_RST = 32'h00000F00;
  // Picture parameter word
  localparam int SJD_PPS_VBR = 0;
  localparam int SJD_PPS_KEY_LSB = 2;
  localparam logic [31:0] SJD_PPS_RST = 32'h00000000;
  // Status fields
  localparam int SJD_STAT_BJ_ERR = 0;
  localparam int SJD_STAT_VBR_ERR = 1;
  // Bus answers
  localparam logic [1:0] SJD_RESP_OKAY = 2'h0;
  localparam logic [1:0] SJD_RESP_SLVERR = 2'h2;
  // Datapath sizes
  localparam int SJD_POS_W = 16;
  localparam int SJD_N_IN = 3;
  localparam int SJD_PIX_W = 30;
endpackage

// ==== hdl/sjd_engine.sv ====
// One compression engine of the datapath: one pixel a clock, never stalls.
// Assumes config words are held steady while pixels flow.
`timescale 1ns/1ps
module sjd_engine #(
  parameter int PIX_W = sjd_pkg::SJD_PIX_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic comp_en,
  input wire logic [31:0] pps,
  // Pixel input
  input wire logic in_valid,
  input wire logic [PIX_W-1:0] in_data,
  input wire logic in_sol,
  // Coded output
  output logic out_valid,
  output logic [PIX_W-1:0] out_data,
  output logic out_sol,
  output logic [31:0] crc
);
  import sjd_pkg::*;

  // The running check word is 32 bits, so wider pixels cannot fold into it
  if (PIX_W < 1 || PIX_W > 32)
  begin : g_bad_param
    $error("sjd_engine: PIX_W must be 1..32");
  end

  typedef struct packed {
    logic ov;
    logic [PIX_W-1:0] od;
    logic os;
    logic [31:0] crc;
  } sjd_eng_s;

  sjd_eng_s st_q;
  sjd_eng_s st_d;
  logic [PIX_W-1:0] key;
  logic [PIX_W-1:0] coded;

  // Rate-control flag bit sits below the key and is never used
  assign key = comp_en ? PIX_W'(pps >> SJD_PPS_KEY_LSB) : '0; // see [R2] see [R10]
  assign coded = in_data ^ key;

  always_comb
  begin
    st_d = st_q;
    st_d.ov = in_valid; // see [R4]
    if (in_valid)
    begin
      st_d.od = coded;
      st_d.os = in_sol;
      st_d.crc = {st_q.crc[30:0], st_q.crc[31]} ^ 32'(coded);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign out_valid = st_q.ov;
  assign out_data = st_q.od;
  assign out_sol = st_q.os;
  assign crc = st_q.crc;
endmodule

// ==== hdl/sjd_datapath.sv ====
// Compression datapath of one pipe: port select, splitter, two engines,
// small joiner and big-joiner merge, with an AXI4-Lite register slave.
// Assumes pixels, peer stream and transcoder line start share aclk.
//
// Overview of operation
// [R1] Horizontal mirror is applied to plane coordinates before rotation.
// [R2] Software never sets the variable bit rate flag; hardware ignores it.
// [R3] Each engine owns its own parameter, rate and CRC registers.
// [R4] Each engine takes one pixel every clock and never stalls.
// [R5] Above one engine's rate both engines run on split halves.
// [R6] Pixel stream comes from one of three selectable input ports.
// [R7] With splitter on, left branch is upper output, right is lower.
// [R8] Joined stream appears only on the left output.
// [R9] Software sets branch widths: slice quarter, picture half of active width.
// [R10] Each engine uses only its own parameter word.
// [R11] Bypass passes raw pixels on the left branch only.
// [R12] Compression without split uses one engine, left branch only.
// [R13] Split without compression gives raw halves on both branches.
// [R14] Split and compress gives both coded halves on separate branches.
// [R15] Small joiner gives one merged stream on left; not with glass panels.
// [R16] Big joiner merges this pipe's stream with the adjacent pipe's; the code takes a peer pixel only in clocks with no own pixel, else drops it.
// [R17] In big joiner mode line timing comes from the transcoder only.
// [R18] Software never enables big joiner with compression bypassed.
// [R19] Software enables small joiner before or with big joiner.
// [R20] A parameter packet word is offered per transcoder.
// [R21] Software enables compression only when link bandwidth needs it.
// [R22] Software picks the largest coded depth that fits the link.
// [R23] Each branch gets its half-line contiguous, in original order.
`timescale 1ns/1ps
module sjd_datapath #(
  parameter int N_IN = sjd_pkg::SJD_N_IN,
  parameter int PIX_W = sjd_pkg::SJD_PIX_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sjd_pkg::SJD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [sjd_pkg::SJD_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Pixel input ports
  input wire logic [N_IN-1:0] pin_valid,
  input wire logic [N_IN-1:0][PIX_W-1:0] pin_data,
  input wire logic [N_IN-1:0] pin_sol,
  // Adjacent pipe and transcoder
  input wire logic peer_valid,
  input wire logic [PIX_W-1:0] peer_data,
  input wire logic tc_sol,
  // Left and right branches
  output logic lo_valid,
  output logic [PIX_W-1:0] lo_data,
  output logic lo_sol,
  output logic ro_valid,
  output logic [PIX_W-1:0] ro_data,
  output logic ro_sol,
  // Plane fetch column and parameter packet
  output logic [sjd_pkg::SJD_POS_W-1:0] plane_src_x,
  output logic [31:0] pps_pkt
);
  import sjd_pkg::*;

  if (N_IN < 1 || N_IN > 4 || PIX_W < 1 || PIX_W > 32)
  begin : g_bad_param
    $error("sjd_datapath: N_IN must be 1..4 and PIX_W 1..32");
  end

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [SJD_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] hact;
    logic [31:0] pps0;
    logic [31:0] pps1;
    logic [SJD_POS_W-1:0] x;
    logic lv;
    logic [PIX_W-1:0] ld;
    logic ls;
    logic rv;
    logic [PIX_W-1:0] rd;
    logic rs;
    logic [SJD_POS_W-1:0] src_x;
    logic [31:0] pkt;
  } sjd_state_s;

  localparam sjd_state_s ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
    ctrl: SJD_CTRL_RST, hact: SJD_HACT_RST, pps0: SJD_PPS_RST, pps1: SJD_PPS_RST,
    default: '0};

  sjd_state_s st_q;
  sjd_state_s st_d;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r & mask;
  endfunction

  // Mode decode
  logic split_w;
  logic comp_w;
  logic joined_w;
  logic bj_w;
  logic [1:0] sel_w;
  assign split_w = st_q.ctrl[SJD_CTRL_SPLIT];
  assign comp_w = st_q.ctrl[SJD_CTRL_COMP];
  assign joined_w = split_w && comp_w && st_q.ctrl[SJD_CTRL_JOIN];
  // Illegal big joiner setups are refused rather than half-merged
  assign bj_w = joined_w && st_q.ctrl[SJD_CTRL_BIGJ]; // see [R18] see [R19]
  assign sel_w = st_q.ctrl[SJD_CTRL_SEL_LSB +: 2];

  // Port select and splitter
  logic v_w;
  logic [PIX_W-1:0] d_w;
  logic s_w;
  logic [SJD_POS_W-1:0] pos_w;
  logic [SJD_POS_W-1:0] half_w;
  logic right_w;
  logic [SJD_POS_W-1:0] flip_w;

  always_comb
  begin
    // Out-of-range selects fall back to port 0
    if (32'(sel_w) < N_IN) // see [R6]
    begin
      v_w = pin_valid[sel_w];
      d_w = pin_data[sel_w];
      s_w = pin_sol[sel_w];
    end
    else
    begin
      v_w = pin_valid[0];
      d_w = pin_data[0];
      s_w = pin_sol[0];
    end
  end

  assign pos_w = s_w ? '0 : st_q.x;
  assign half_w = {1'b0, st_q.hact[SJD_POS_W-1:1]};
  // Lower half-line to the left engine, upper half to the right
  assign right_w = split_w && (pos_w >= half_w); // see [R7] see [R23]
  // Mirror first, then 180-degree turn
  assign flip_w = st_q.ctrl[SJD_CTRL_HFLIP] ? st_q.hact[SJD_POS_W-1:0] - 16'h0001 - pos_w : pos_w; // see [R1]

  // Engines
  logic e0_ov;
  logic [PIX_W-1:0] e0_od;
  logic e0_os;
  logic [31:0] e0_crc;
  logic e1_ov;
  logic [PIX_W-1:0] e1_od;
  logic e1_os;
  logic [31:0] e1_crc;

  // Two register sets, one bound to each engine
  sjd_engine #(.PIX_W(PIX_W)) u_eng0 ( // see [R3]
    .aclk(aclk),
    .aresetn(aresetn),
    .comp_en(comp_w),
    .pps(st_q.pps0),
    .in_valid(v_w && !right_w),
    .in_data(d_w),
    .in_sol(s_w),
    .out_valid(e0_ov),
    .out_data(e0_od),
    .out_sol(e0_os),
    .crc(e0_crc)
  );

  // Runs beside engine 0 so the pair carries the whole line
  sjd_engine #(.PIX_W(PIX_W)) u_eng1 ( // see [R5]
    .aclk(aclk),
    .aresetn(aresetn),
    .comp_en(comp_w),
    .pps(st_q.pps1),
    .in_valid(v_w && right_w),
    .in_data(d_w),
    .in_sol(pos_w == half_w),
    .out_valid(e1_ov),
    .out_data(e1_od),
    .out_sol(e1_os),
    .crc(e1_crc)
  );

  always_comb
  begin
    st_d = st_q;
    // Write channel: address and data in either order
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.awaddr = s_axi_awaddr;
      st_d.awready = 1'b0;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
      st_d.wready = 1'b0;
    end
    if (!st_q.awready && !st_q.wready && !st_q.bvalid)
    begin
      st_d.bvalid = 1'b1;
      st_d.bresp = SJD_RESP_OKAY;
      case ({st_q.awaddr[SJD_ADDR_W-1:2], 2'b00})
        SJD_OFF_CTRL: st_d.ctrl = wmerge(st_q.ctrl, st_q.wdata, st_q.wstrb, SJD_CTRL_MASK);
        SJD_OFF_HACT: st_d.hact = wmerge(st_q.hact, st_q.wdata, st_q.wstrb, SJD_HACT_MASK);
        SJD_OFF_PPS_E0: st_d.pps0 = wmerge(st_q.pps0, st_q.wdata, st_q.wstrb, '1); // see [R10]
        SJD_OFF_PPS_E1: st_d.pps1 = wmerge(st_q.pps1, st_q.wdata, st_q.wstrb, '1);
        SJD_OFF_CRC_E0, SJD_OFF_CRC_E1, SJD_OFF_STAT: st_d.bresp = SJD_RESP_OKAY;
        default: st_d.bresp = SJD_RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready = 1'b1;
    end
    // Read channel
    if (s_axi_arvalid && st_q.arready)
    begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rresp = SJD_RESP_OKAY;
      case ({s_axi_araddr[SJD_ADDR_W-1:2], 2'b00})
        SJD_OFF_CTRL: st_d.rdata = st_q.ctrl;
        SJD_OFF_HACT: st_d.rdata = st_q.hact;
        SJD_OFF_PPS_E0: st_d.rdata = st_q.pps0;
        SJD_OFF_PPS_E1: st_d.rdata = st_q.pps1;
        SJD_OFF_CRC_E0: st_d.rdata = e0_crc;
        SJD_OFF_CRC_E1: st_d.rdata = e1_crc;
        SJD_OFF_STAT:
        begin
          st_d.rdata = '0;
          st_d.rdata[SJD_STAT_BJ_ERR] = st_q.ctrl[SJD_CTRL_BIGJ] && !joined_w;
          st_d.rdata[SJD_STAT_VBR_ERR] = st_q.pps0[SJD_PPS_VBR] || st_q.pps1[SJD_PPS_VBR];
        end
        default:
        begin
          st_d.rdata = '0;
          st_d.rresp = SJD_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end
    // Line position and plane fetch column
    if (v_w)
    begin
      st_d.x = pos_w + 16'h0001;
      st_d.src_x = st_q.ctrl[SJD_CTRL_ROT] ? st_q.hact[SJD_POS_W-1:0] - 16'h0001 - flip_w : flip_w; // see [R1]
    end
    // Branch outputs: bypass and compress-only use the left branch only
    st_d.lv = e0_ov; // see [R11] see [R12]
    st_d.ld = e0_od;
    st_d.ls = e0_os;
    st_d.rv = 1'b0;
    st_d.rd = st_q.rd;
    st_d.rs = 1'b0;
    if (joined_w)
    begin
      // Halves arrive one after the other, so no joiner buffer is needed
      if (!e0_ov && e1_ov) // see [R8] see [R15]
      begin
        st_d.lv = 1'b1;
        st_d.ld = e1_od;
        st_d.ls = 1'b0;
      end
    end
    else if (split_w)
    begin
      st_d.rv = e1_ov; // see [R13] see [R14]
      st_d.rd = e1_od;
      st_d.rs = e1_os;
    end
    if (bj_w)
    begin
      if (!st_d.lv && peer_valid) // see [R16]
      begin
        st_d.lv = 1'b1;
        st_d.ld = peer_data;
      end
      st_d.ls = tc_sol; // see [R17]
    end
    // Packet word for this pipe's transcoder, rate flag forced off
    st_d.pkt = st_q.pps0 & ~(32'h00000001 << SJD_PPS_VBR); // see [R20] see [R2]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign lo_valid = st_q.lv;
  assign lo_data = st_q.ld;
  assign lo_sol = st_q.ls;
  assign ro_valid = st_q.rv;
  assign ro_data = st_q.rd;
  assign ro_sol = st_q.rs;
  assign plane_src_x = st_q.src_x;
  assign pps_pkt = st_q.pkt;

  // Checks; all assume the mode is not rewritten while pixels flow
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [PIX_W-1:0] key0_w;
  logic [PIX_W-1:0] key1_w;
  assign key0_w = comp_w ? PIX_W'(st_q.pps0 >> SJD_PPS_KEY_LSB) : '0;
  assign key1_w = comp_w ? PIX_W'(st_q.pps1 >> SJD_PPS_KEY_LSB) : '0;

  a_port_select: assert property ( // see [R6]
    (pin_valid[0] && sel_w == 2'h0 && !split_w) |-> ##2 (lo_valid && lo_data == ($past(pin_data[0], 2) ^ key0_w)))
    else $error("selected port 0 pixel missing on left branch");
  a_engine_rate: assert property (v_w && !right_w |=> e0_ov) // see [R4]
    else $error("engine did not take pixel in one clock");
  a_bypass_left: assert property ( // see [R11]
    (v_w && !split_w && !comp_w) |-> ##2 (lo_valid && !ro_valid && lo_data == $past(d_w, 2)))
    else $error("bypass pixel not raw on left only");
  a_compress_only: assert property ( // see [R12]
    (v_w && !split_w && comp_w) |-> ##2 (lo_valid && !ro_valid && lo_data == ($past(d_w, 2) ^ key0_w)))
    else $error("single engine output wrong");
  a_split_right: assert property ( // see [R14]
    (v_w && right_w && !joined_w) |-> ##2 (ro_valid && !lo_valid && ro_data == ($past(d_w, 2) ^ key1_w)))
    else $error("right half not on right branch with its own key");
  a_split_left: assert property ((v_w && split_w && !right_w) |-> ##2 lo_valid) // see [R23]
    else $error("left half pixel lost");
  a_join_single: assert property ($past(joined_w) |-> !ro_valid) // see [R8]
    else $error("joined stream leaked to right branch");
  a_bigj_timing: assert property ($past(bj_w) |-> (lo_sol == $past(tc_sol))) // see [R17]
    else $error("big joiner line start not from transcoder");
  a_flip_order: assert property ( // see [R1]
    (v_w && st_q.ctrl[SJD_CTRL_HFLIP] && st_q.ctrl[SJD_CTRL_ROT]) |=> (plane_src_x == $past(pos_w)))
    else $error("flip then turn should give identity column");
  a_write_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped before taken");

  c_split_run: cover property (ro_valid ##1 ro_valid);
  c_join_merge: cover property (joined_w && e1_ov && !e0_ov);
  c_bigj_peer: cover property (bj_w && peer_valid && !e0_ov && !e1_ov);
endmodule

// ==== tb/sjd_pipe_model.sv ====
// Upstream pipe model: sends one line of counting pixels on a chosen port.
// Assumes the bench pulses go for one clock and waits while busy is high.
`timescale 1ns/1ps
module sjd_pipe_model #(
  parameter int N_IN = 3,
  parameter int PIX_W = 30
) (
  // Clock
  input wire logic aclk,
  // Line request
  input wire logic go,
  input wire logic [1:0] port,
  input wire logic [PIX_W-1:0] base,
  input wire logic [7:0] len,
  // Pixel ports and line start
  output logic [N_IN-1:0] pin_valid,
  output logic [N_IN-1:0][PIX_W-1:0] pin_data,
  output logic [N_IN-1:0] pin_sol,
  output logic tc_sol,
  output logic busy
);
  logic [7:0] cnt_q;
  logic [7:0] len_q;
  logic [1:0] port_q;
  logic [PIX_W-1:0] base_q;

  initial
  begin
    cnt_q = '0;
    pin_valid = '0;
    pin_data = '0;
    pin_sol = '0;
    tc_sol = 1'b0;
    busy = 1'b0;
  end

  always @(posedge aclk)
  begin
    pin_valid <= '0;
    pin_sol <= '0;
    tc_sol <= 1'b0;
    // Idle lanes toggle so a stale value never looks like a pixel
    for (int p = 0; p < N_IN; p++)
      pin_data[p] <= ~pin_data[p];
    if (go)
    begin
      cnt_q <= len;
      len_q <= len;
      port_q <= port;
      base_q <= base;
      busy <= 1'b1;
    end
    else if (cnt_q != 8'h00)
    begin
      // Back-to-back pixels, one each clock
      pin_valid[port_q] <= 1'b1;
      pin_data[port_q] <= base_q + PIX_W'(len_q - cnt_q);
      pin_sol[port_q] <= (cnt_q == len_q);
      tc_sol <= (cnt_q == len_q);
      cnt_q <= cnt_q - 8'h01;
      busy <= (cnt_q != 8'h01);
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench of the split/join datapath: AXI4-Lite setup, then lines.
// Assumes the 2-clock pixel latency and register map of the package.
`timescale 1ns/1ps
module tb_top;
  import sjd_pkg::*;
  localparam int PW = SJD_PIX_W;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lo_valid, lo_sol, ro_valid, ro_sol, tc_sol, m_go, m_busy;
  logic [7:0] awaddr, araddr, m_len;
  logic [31:0] wdata, rdata, pps_pkt, pps0, pps1;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, m_port;
  logic [2:0] pin_valid, pin_sol;
  logic [2:0][PW-1:0] pin_data;
  logic [PW-1:0] lo_data, ro_data, m_base;
  logic peer_valid;
  logic [PW-1:0] peer_data;
  logic [SJD_POS_W-1:0] src_x;
  logic [30:0] lo_q[$], ro_q[$];
  int miscompares, checked;

  sjd_datapath u_sjd_datapath (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pin_valid(pin_valid), .pin_data(pin_data), .pin_sol(pin_sol),
    .peer_valid(peer_valid), .peer_data(peer_data), .tc_sol(tc_sol),
    .lo_valid(lo_valid), .lo_data(lo_data), .lo_sol(lo_sol),
    .ro_valid(ro_valid), .ro_data(ro_data), .ro_sol(ro_sol),
    .plane_src_x(src_x), .pps_pkt(pps_pkt));

  sjd_pipe_model u_sjd_pipe_model (.aclk(aclk), .go(m_go), .port(m_port), .base(m_base),
    .len(m_len), .pin_valid(pin_valid), .pin_data(pin_data), .pin_sol(pin_sol),
    .tc_sol(tc_sol), .busy(m_busy));

  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // Outputs are registered, so the falling edge sees settled values
  always @(negedge aclk)
  begin
    if (lo_valid === 1'b1) lo_q.push_back({lo_sol, lo_data});
    if (ro_valid === 1'b1) ro_q.push_back({ro_sol, ro_data});
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic awp, wp, aw_t, w_t, hs;
    logic [1:0] r;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; bready <= 1'b1;
    awp = 1'b1; wp = 1'b1; hs = 1'b0; n = 0;
    while (!hs && n < 100)
    begin
      @(negedge aclk);
      aw_t = awp && awready === 1'b1;
      w_t = wp && wready === 1'b1;
      hs = bvalid === 1'b1;
      r = bresp;
      @(posedge aclk);
      if (aw_t) begin awvalid <= 1'b0; awp = 1'b0; end
      if (w_t) begin wvalid <= 1'b0; wp = 1'b0; end
      n++;
    end
    bready <= 1'b0;
    chk("write answer", 32'h00000001, {31'h0, hs});
    chk("bresp", {30'h0, er}, {30'h0, r});
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic arp, ar_t, hs;
    logic [31:0] d;
    logic [1:0] r;
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    arp = 1'b1; hs = 1'b0; n = 0;
    while (!hs && n < 100)
    begin
      @(negedge aclk);
      ar_t = arp && arready === 1'b1;
      hs = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) begin arvalid <= 1'b0; arp = 1'b0; end
      n++;
    end
    rready <= 1'b0;
    chk("read answer", 32'h00000001, {31'h0, hs});
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
    @(posedge aclk);
  endtask

  // One 8-pixel line; active width is 8, so the halves split at position 4
  task automatic run_line(input logic [1:0] p, input logic [PW-1:0] b, input logic [PW-1:0] kl,
    input logic [PW-1:0] kr, input logic split, input logic joined);
    logic [30:0] el[$], er[$], m;
    logic [PW-1:0] px;
    logic rt;
    int n;
    lo_q.delete();
    ro_q.delete();
    m_go <= 1'b1; m_port <= p; m_base <= b; m_len <= 8'd8;
    @(posedge aclk);
    m_go <= 1'b0;
    n = 0;
    do begin @(negedge aclk); n++; end while (m_busy !== 1'b0 && n < 50);
    chk("line done", 32'h00000000, {31'h0, m_busy});
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 8; i++)
    begin
      px = b + PW'(i);
      rt = split && i >= 4;
      if (rt && !joined) er.push_back({i == 4, px ^ kr});
      else el.push_back({i == 0, px ^ (rt ? kr : kl)});
    end
    // Start marks of the merged stream are left open, so only data is judged there
    m = joined ? 31'h3FFFFFFF : 31'h7FFFFFFF;
    chk("left count", el.size(), lo_q.size());
    chk("right count", er.size(), ro_q.size());
    for (int i = 0; i < el.size() && i < lo_q.size(); i++) chk("left pixel", {1'b0, el[i] & m}, {1'b0, lo_q[i] & m});
    for (int i = 0; i < er.size() && i < ro_q.size(); i++) chk("right pixel", {1'b0, er[i]}, {1'b0, ro_q[i]});
  endtask

  task automatic t_reset_regs();
    rd_chk(SJD_OFF_CTRL, SJD_CTRL_RST, SJD_RESP_OKAY);
    rd_chk(SJD_OFF_HACT, SJD_HACT_RST, SJD_RESP_OKAY);
    rd_chk(SJD_OFF_PPS_E0, SJD_PPS_RST, SJD_RESP_OKAY);
    rd_chk(SJD_OFF_PPS_E1, SJD_PPS_RST, SJD_RESP_OKAY);
    rd_chk(8'h1C, 32'h00000000, SJD_RESP_SLVERR);
    $display("test reset_regs done");
  endtask

  task automatic t_reg_access();
    axi_wr(SJD_OFF_HACT, 32'h00000008, SJD_RESP_OKAY);
    axi_wr(SJD_OFF_PPS_E0, pps0, SJD_RESP_OKAY);
    axi_wr(SJD_OFF_PPS_E1, pps1, SJD_RESP_OKAY);
    rd_chk(SJD_OFF_PPS_E0, pps0, SJD_RESP_OKAY);
    rd_chk(SJD_OFF_PPS_E1, pps1, SJD_RESP_OKAY);
    @(negedge aclk);
    chk("parameter packet", pps0, pps_pkt);
    @(posedge aclk);
    axi_wr(SJD_OFF_CRC_E0, 32'hFFFFFFFF, SJD_RESP_OKAY);
    rd_chk(SJD_OFF_CRC_E0, 32'h00000000, SJD_RESP_OKAY);
    axi_wr(8'h20, 32'h12345678, SJD_RESP_SLVERR);
    axi_wr(SJD_OFF_CTRL, 32'h00000008, SJD_RESP_OKAY);
    rd_chk(SJD_OFF_STAT, 32'h00000001, SJD_RESP_OKAY);
    $display("test reg_access done");
  endtask

  task automatic t_modes();
    axi_wr(SJD_OFF_CTRL, 32'h00000100, SJD_RESP_OKAY);
    run_line(2'd1, 30'h0ABC0000, '0, '0, 1'b0, 1'b0);
    axi_wr(SJD_OFF_CTRL, 32'h00000202, SJD_RESP_OKAY);
    run_line(2'd2, 30'h01230000, pps0[31:2], pps0[31:2], 1'b0, 1'b0);
    axi_wr(SJD_OFF_CTRL, 32'h00000001, SJD_RESP_OKAY);
    run_line(2'd0, 30'h02220000, '0, '0, 1'b1, 1'b0);
    axi_wr(SJD_OFF_CTRL, 32'h00000103, SJD_RESP_OKAY);
    run_line(2'd1, 30'h03330000, pps0[31:2], pps1[31:2], 1'b1, 1'b0);
    axi_wr(SJD_OFF_CTRL, 32'h00000207, SJD_RESP_OKAY);
    run_line(2'd2, 30'h04440000, pps0[31:2], pps1[31:2], 1'b1, 1'b1);
    axi_wr(SJD_OFF_CTRL, 32'h0000020F, SJD_RESP_OKAY);
    run_line(2'd2, 30'h05550000, pps0[31:2], pps1[31:2], 1'b1, 1'b1);
    // Last pixel sits at column 7 of an 8-wide line
    axi_wr(SJD_OFF_CTRL, 32'h00000010, SJD_RESP_OKAY);
    run_line(2'd0, 30'h06660000, '0, '0, 1'b0, 1'b0);
    chk("mirrored column", 32'h00000000, {16'h0000, src_x});
    axi_wr(SJD_OFF_CTRL, 32'h00000030, SJD_RESP_OKAY);
    run_line(2'd0, 30'h07770000, '0, '0, 1'b0, 1'b0);
    chk("mirror then turn column", 32'h00000007, {16'h0000, src_x});
    $display("test modes done");
  endtask

  // One peer pixel offered while both engines idle; merged only in full big joiner mode
  task automatic peer_px(input logic [31:0] ctl, input logic [31:0] en);
    axi_wr(SJD_OFF_CTRL, ctl, SJD_RESP_OKAY);
    lo_q.delete();
    peer_valid <= 1'b1;
    peer_data <= 30'h15A5A5A5;
    @(posedge aclk);
    peer_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("peer pixel count", en, lo_q.size());
    if (en != 0 && lo_q.size() != 0) chk("peer pixel", {2'b00, 30'h15A5A5A5}, {1'b0, lo_q[0]});
  endtask

  task automatic t_bigj();
    peer_px(32'h00000008, 32'h00000000);
    peer_px(32'h0000000D, 32'h00000000);
    peer_px(32'h0000000F, 32'h00000001);
    $display("test big_joiner done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    aresetn = 1'b0; awvalid = 1'b0; awaddr = '0; wvalid = 1'b0; wdata = '0; wstrb = '0;
    bready = 1'b0; arvalid = 1'b0; araddr = '0; rready = 1'b0;
    m_go = 1'b0; m_port = '0; m_base = '0; m_len = '0;
    peer_valid = 1'b0; peer_data = '0;
    miscompares = 0; checked = 0;
    // Rate flag kept clear in both words
    pps0 = 32'h5A5A1234;
    pps1 = 32'hC3C30F08;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_regs();
    t_reg_access();
    t_modes();
    t_bigj();
    end_sim();
  end

  // Whole run needs well under a thousand clocks
  initial
  begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    end_sim();
  end
endmodule
